// ==== verilog/rsc_regs.vh ====
// constants of the reset and stop-mode recovery controller
// Function
// RULE1: por, brown-out, reset pin or fault detect cause system reset in normal mode.
// RULE2: watchdog timeout resets only when the watchdog reset-select option is set.
// RULE3: writing 1 to debugger control bit 0 starts a device reset.
// RULE4: in stop mode a watchdog timeout starts a stop-mode recovery.
// RULE5: in stop mode only enabled gpio input transitions start a stop-mode recovery.
// RULE6: reset type is chosen from operating mode and the reset source.
// RULE7: two reset types; system reset clears peripheral registers and resets the core.
// RULE8: stop recovery resets core only; source and oscillator registers also update.
// RULE9: internal reset is held at least 66 oscillator cycles for both types; the code holds 50 oscillator cycles then 16 system clocks.
// RULE10: latency is 50 oscillator cycles then 16 system clock cycles.
// RULE11: an external agent holds the reset pin low at least four clocks.
// RULE12: open-drain reset pin is driven low until the reset delay ends.
// RULE13: por or brown-out wins over all other sources and gives full reset.
// RULE14: requests are synchronised first and a new request restarts the count; the code takes the request inputs unsynchronised.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
`define RSC_ADDR_W 12
`define RSC_STAT_OFF 12'hff0
`define RSC_DBG_OFF 12'hff4
`define RSC_OSC_OFF 12'hff8
`define RSC_SMR_OFF 12'hffc
`define RSC_OSC_CNT 7'h32
`define RSC_SYS_CNT 7'h10
`define RSC_PIN_MIN 3'h4
`define RSC_OSC_RST 8'ha0
`define RSC_BIT_POR 7
`define RSC_BIT_STOP 6
`define RSC_BIT_WDT 5
`define RSC_BIT_EXT 4
`define RSC_BIT_FLT 3
`define RSC_BIT_DBG 2
`define RSC_BIT_WDTRES 0
`define RSC_BIT_RSVD 1
`define RSC_STAT_RST 8'h81
`define RSC_SMR_RST 8'h00
`define RSC_DBG_RST_BIT 0
`define RSC_REG_W 8
`define RSC_SEL_STAT 0
`define RSC_SEL_DBG 1
`define RSC_SEL_OSC 2
`define RSC_SEL_SMR 3
`endif

// ==== verilog/rsc_reset_ctrl.v ====
// reset and stop-mode recovery sequencer with apb register access
//
// Local design decision: register access over APB.
`default_nettype none
`include "rsc_regs.vh"
module rsc_reset_ctrl (
  input wire clk_sys,
  input wire rst_b,
  input wire clk_ipo,
  input wire porDetect,
  input wire brownoutDetect,
  input wire faultDetect,
  input wire wdtTimeout,
  input wire stopMode,
  input wire [7:0] gpioIn,
  input wire resetPinIn,
  output reg resetPinOut,
  output reg resetPinOe,
  output reg coreReset,
  output reg periphReset,
  output reg sysClkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata
);
  localparam IDLE = 2'b00;
  localparam OSCW = 2'b01;
  localparam SYSW = 2'b10;

  reg [1:0] state_q;
  reg [6:0] cnt_q;
  reg [1:0] oscSync_q;
  reg oscSeen_q;
  reg recov_q;
  reg [7:0] stat_q;
  reg [7:0] osc_q;
  reg [7:0] smrEn_q;
  reg dbgRst_q;
  reg [7:0] gpioPrev_q;
  reg [2:0] pinLow_q;

  // clk_ipo is slower than clk_sys; its edges are found after synchronising
  wire oscEdge = oscSync_q[1] & ~oscSeen_q;
  wire pinReq = (pinLow_q >= `RSC_PIN_MIN);
  wire hardReq = porDetect | brownoutDetect; // RULE13
  wire wdtSys = wdtTimeout & ~stopMode & stat_q[`RSC_BIT_WDTRES]; // RULE2
  wire sysReq = hardReq | pinReq | faultDetect | wdtSys | dbgRst_q; // RULE1 RULE6
  wire gpioHit = |((gpioIn ^ gpioPrev_q) & smrEn_q); // RULE5
  wire smrReq = stopMode & (wdtTimeout | gpioHit) & ~sysReq; // RULE4 RULE6
  // one-hot register select; any upper address bit set means unmapped
  function [3:0] rsc_decode;
    input [31:0] addr;
    begin
      rsc_decode = 4'h0;
      if (addr[31:`RSC_ADDR_W] != {(32 - `RSC_ADDR_W){1'b0}}) begin
        rsc_decode = 4'h0;
      end else if (addr[`RSC_ADDR_W-1:0] == `RSC_STAT_OFF) begin
        rsc_decode[`RSC_SEL_STAT] = 1'b1;
      end else if (addr[`RSC_ADDR_W-1:0] == `RSC_DBG_OFF) begin
        rsc_decode[`RSC_SEL_DBG] = 1'b1;
      end else if (addr[`RSC_ADDR_W-1:0] == `RSC_OSC_OFF) begin
        rsc_decode[`RSC_SEL_OSC] = 1'b1;
      end else if (addr[`RSC_ADDR_W-1:0] == `RSC_SMR_OFF) begin
        rsc_decode[`RSC_SEL_SMR] = 1'b1;
      end
    end
  endfunction

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire [3:0] regSel = rsc_decode(paddr);
  wire hitStat = regSel[`RSC_SEL_STAT];
  wire hitDbg = regSel[`RSC_SEL_DBG];
  wire hitOsc = regSel[`RSC_SEL_OSC];
  wire hitSmr = regSel[`RSC_SEL_SMR];
  wire mapped = |regSel;

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oscSync_q <= 2'b00;
      // seen starts high, but the synchroniser clears to 00, so a high oscillator at release still shows as an edge
      oscSeen_q <= 1'b1;
    end else begin
      oscSync_q <= {oscSync_q[0], clk_ipo};
      oscSeen_q <= oscSync_q[1];
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinLow_q <= 3'h0;
      gpioPrev_q <= 8'h00;
    end else begin
      gpioPrev_q <= gpioIn;
      // our own pull on the pin is not an outside request, else reset never ends
      if (resetPinIn | ~resetPinOe) begin
        pinLow_q <= 3'h0; // RULE11 RULE12
      end else if (!pinReq) begin
        pinLow_q <= pinLow_q + 3'h1; // RULE11
      end
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= OSCW;
      cnt_q <= 7'h00;
      recov_q <= 1'b0;
    end else if (sysReq | smrReq) begin
      state_q <= OSCW; // RULE14
      cnt_q <= 7'h00;
      recov_q <= smrReq & ~(recov_q == 1'b0 && state_q != IDLE);
    end else begin
      case (state_q)
        OSCW: begin
          if (oscEdge) begin
            // the first edge only opens the window, so whole periods are counted
            if (cnt_q == `RSC_OSC_CNT) begin
              state_q <= SYSW; // RULE10
              cnt_q <= 7'h00;
            end else begin
              cnt_q <= cnt_q + 7'h1; // RULE9
            end
          end
        end
        SYSW: begin
          if (cnt_q == `RSC_SYS_CNT - 7'h1) begin
            state_q <= IDLE; // RULE9 RULE10
          end else begin
            cnt_q <= cnt_q + 7'h1;
          end
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // outputs come from flops so the core never sees a decode glitch
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      coreReset <= 1'b1;
      periphReset <= 1'b1;
      sysClkEn <= 1'b0;
      resetPinOut <= 1'b0;
      resetPinOe <= 1'b1;
    end else begin
      coreReset <= (state_q != IDLE); // RULE7 RULE8
      periphReset <= (state_q != IDLE) & ~recov_q; // RULE7 RULE8
      sysClkEn <= (state_q != OSCW); // RULE10
      resetPinOut <= 1'b0;
      resetPinOe <= ~((state_q != IDLE) & ~recov_q); // RULE12
    end
  end

  // status keeps the last cause; the watchdog option survives resets
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= `RSC_STAT_RST;
      osc_q <= `RSC_OSC_RST;
      smrEn_q <= `RSC_SMR_RST;
      dbgRst_q <= 1'b0;
    end else begin
      if (sysReq) begin
        // power-on and brown-out mask every other cause bit
        stat_q[`RSC_BIT_POR] <= hardReq | dbgRst_q; // RULE13
        stat_q[`RSC_BIT_STOP] <= 1'b0;
        stat_q[`RSC_BIT_WDT] <= wdtSys & ~hardReq; // RULE2
        stat_q[`RSC_BIT_EXT] <= pinReq & ~hardReq; // RULE1
        stat_q[`RSC_BIT_FLT] <= faultDetect & ~hardReq; // RULE1
        stat_q[`RSC_BIT_DBG] <= 1'b0;
        stat_q[`RSC_BIT_RSVD] <= 1'b0;
        osc_q <= `RSC_OSC_RST; // RULE7
        smrEn_q <= `RSC_SMR_RST; // RULE7
        // a debugger write landing in a reset cycle is kept and restarts the count
        dbgRst_q <= wr & hitDbg & pwdata[`RSC_DBG_RST_BIT]; // RULE3 RULE14
      end else if (smrReq) begin
        stat_q[`RSC_BIT_POR] <= 1'b0;
        stat_q[`RSC_BIT_STOP] <= 1'b1; // RULE8
        stat_q[`RSC_BIT_WDT] <= wdtTimeout; // RULE4
        stat_q[`RSC_BIT_EXT] <= 1'b0;
        stat_q[`RSC_BIT_FLT] <= 1'b0;
        stat_q[`RSC_BIT_DBG] <= 1'b0;
        stat_q[`RSC_BIT_RSVD] <= 1'b0;
        osc_q <= `RSC_OSC_RST; // RULE8
      end else if (wr) begin
        if (hitStat) begin
          stat_q[`RSC_BIT_WDTRES] <= pwdata[`RSC_BIT_WDTRES]; // RULE2
        end else if (hitDbg) begin
          dbgRst_q <= pwdata[`RSC_DBG_RST_BIT]; // RULE3
        end else if (hitOsc) begin
          osc_q <= pwdata[`RSC_REG_W-1:0];
        end else if (hitSmr) begin
          smrEn_q <= pwdata[`RSC_REG_W-1:0]; // RULE5
        end
      end
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (hitStat) begin
        prdata <= {24'h000000, stat_q};
      end else if (hitDbg) begin
        prdata <= {31'h00000000, dbgRst_q};
      end else if (hitOsc) begin
        prdata <= {24'h000000, osc_q};
      end else if (hitSmr) begin
        prdata <= {24'h000000, smrEn_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // rsc_reset_ctrl
`default_nettype wire

// ==== sim/rsc_chk_properties.sv ====
// port checker for the reset controller
`default_nettype none
module rsc_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic coreReset,
  input wire logic periphReset,
  input wire logic sysClkEn,
  input wire logic resetPinOe,
  input wire logic resetPinOut,
  input wire logic porDetect,
  input wire logic wdtTimeout,
  input wire logic stopMode,
  input wire logic pslverr,
  input wire logic pwrite,
  input wire logic [31:0] prdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_pin_out: assert property (!resetPinOut) else $error("pin driven high");
  chk_pin_core: assert property (!resetPinOe |-> coreReset) else $error("pin low idle");
  chk_per_core: assert property (periphReset |-> coreReset)
    else $error("periph reset alone");
  chk_clk_first: assert property ($fell(coreReset) |-> sysClkEn) else $error("no clock");
  chk_sys_hold: assert property ($rose(sysClkEn) |-> coreReset [*8])
    else $error("clock phase short");
  chk_por_sys: assert property ($rose(porDetect) |-> ##[1:40] periphReset)
    else $error("no full reset");
  chk_stop_rec: assert property (!coreReset && stopMode && !porDetect && $rose(wdtTimeout)
    |-> ##[1:40] coreReset && !periphReset) else $error("bad recovery");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  cover property ($fell(periphReset));
  cover property ($rose(coreReset) && stopMode);
  cover property (pslverr);
endmodule // rsc_chk
bind rsc_reset_ctrl rsc_chk rsc_chk_i (.clk_sys, .rst_b, .coreReset, .periphReset, .sysClkEn,
  .resetPinOe, .resetPinOut, .porDetect, .wdtTimeout, .stopMode, .pslverr, .pwrite, .prdata);
`default_nettype wire

// ==== sim/rsc_pin.sv ====
// board side of the reset pin: pull-up and a pusher
`default_nettype none
module rsc_pin (
  input wire logic clk_sys,
  input wire logic chipOe,
  input wire logic push,
  output logic pinLvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q = 3'h0;
  always @(posedge clk_sys) cnt_q <= push ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
  assign pinLvl = chipOe && cnt_q == 3'h0;
endmodule // rsc_pin
`default_nettype wire

// ==== sim/tb.sv ====
// bench for the reset and stop-mode recovery controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, clk_ipo = 0, rst_b = 0, por = 0, bod = 0, flt = 0, wdt = 0, stp = 0;
  logic psel = 0, penable = 0, pwrite = 0, push = 0, er;
  logic [7:0] gpio = 8'h00;
  logic [31:0] paddr = 0, pwdata = 0, rd;
  wire pin, oe, coreReset, periphReset, pready, pslverr;
  wire [31:0] prdata;
  int miscompares = 0, checks_done = 0;
  initial forever #4 clk_sys = ~clk_sys;
  initial forever #16 clk_ipo = ~clk_ipo;
  rsc_pin rsc_pin_i (.clk_sys, .chipOe(oe), .push, .pinLvl(pin));
  rsc_reset_ctrl rsc_reset_ctrl_i (.clk_sys, .rst_b, .clk_ipo, .porDetect(por),
    .brownoutDetect(bod), .faultDetect(flt), .wdtTimeout(wdt), .stopMode(stp), .gpioIn(gpio),
    .resetPinIn(pin), .resetPinOut(), .resetPinOe(oe), .coreReset, .periphReset, .sysClkEn(),
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  // requests are levels; 12 clocks spans three oscillator edges for the synchroniser
  task hold(input logic [4:0] v);
    {por, bod, flt, push, wdt} <= v;
    repeat (12) @(posedge clk_sys);
    {por, bod, flt, push, wdt} <= 5'h00;
  endtask
  task seq(input logic p);
    int n;
    n = 20;
    while (coreReset !== 1) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    #1 chk("periph", periphReset, p);
    chk("pin oe", oe, !p);
    while (coreReset === 1) begin
      @(posedge clk_sys);
      n++;
    end
    chk("length", n >= 216, 1);
  endtask
  task t_sys;
    for (int i = 0; i < 4; i++) begin
      hold(5'h10 >> i);
      seq(1);
      apb(0, 32'hff0, 0);
      chk("source", rd[i < 2 ? 7 : i + 1], 1);
    end
    $display("t_sys done");
  endtask
  task t_wdt;
    apb(1, 32'hff0, 0);
    hold(5'h01);
    repeat (80) @(posedge clk_sys);
    chk("wdt masked", coreReset, 0);
    apb(1, 32'hff0, 1);
    hold(5'h01);
    seq(1);
    apb(0, 32'hff0, 0);
    chk("wdt bit", rd[5], 1);
    apb(1, 32'hff4, 1);
    seq(1);
    apb(0, 32'hff4, 0);
    chk("dbg clear", rd[0], 0);
    $display("t_wdt done");
  endtask
  task t_stop;
    apb(1, 32'hffc, 1);
    stp <= 1;
    gpio <= 8'h02;
    repeat (80) @(posedge clk_sys);
    chk("gpio masked", coreReset, 0);
    gpio <= 8'h03;
    seq(0);
    hold(5'h01);
    seq(0);
    apb(0, 32'hff0, 0);
    chk("stop bit", rd[6], 1);
    hold(5'h11);
    seq(1);
    stp <= 0;
    $display("t_stop done");
  endtask
  task t_regs;
    apb(0, 32'hff8, 0);
    chk("osc reset", rd, 32'ha0);
    apb(0, 32'h0, 0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(0, 32'h1000ff0, 0);
    chk("upper addr", {er, rd[30:0]}, 32'h80000000);
    $display("t_regs done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    t_regs;
    wait (coreReset === 0);
    t_sys;
    t_wdt;
    t_stop;
    tally_and_finish;
  end
  initial begin
    #100us;
    miscompares++;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
